// ---- core/slic_controller.sv ----
// controller end: apb registers, mode lines, ring cadence sequencer
// ==========================================================
// How it works
// - mode chosen only by three logic lines
// - drive only the four legal combinations
// - deny low forces power denial
// - ignore both detectors during power denial
// - high battery ringing/standby, low battery active
// - cadence high in bursts, low silent
// - seven alerting patterns from interval table
// - cadence selects centering or clamp, never both
// - cadence held low in active mode
// - standby keeps clamp, hook detect valid
// - active mode ignores ring trip detect
// - ring trip only from trip detector
// - battery select high means high battery
// - cadence high floats clamp, low grounds
`timescale 1ns/10ps
`default_nettype none
module slic_controller
  import slic_mode_pkg::*;
#(
  parameter int unsigned TICK = TICK_CYCLES
)(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // interrupt
  output logic             irq,
  // line
  slic_ctl_if.controller   line
);
  // ==========================================================
  // detector synchronisers
  logic [1:0] ds1, ds2, next_ds1;
  always_comb next_ds1 = {line.hook_detect_n, line.ring_trip_detect_n};
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ds1 <= 2'h3;
      ds2 <= 2'h3;
    end else begin
      ds1 <= next_ds1;
      ds2 <= ds1;
    end
  end
  // ==========================================================
  // registers
  line_mode_e reqMode, next_reqMode;
  logic [2:0] pattern, next_pattern;
  logic [2:0] irqSt, next_irqSt, irqEn, next_irqEn;
  logic       tripEv, hookEv, badEv;
  logic       wr, rd;
  always_comb begin
    wr = psel && penable && pwrite;
    rd = psel && penable && !pwrite;
    next_reqMode = reqMode;
    next_pattern = pattern;
    next_irqEn   = irqEn;
    next_irqSt   = irqSt;
    pslverr = psel && penable && !(paddr == REG_CTRL ||
              paddr == REG_STATUS || paddr == REG_IRQ_ST ||
              paddr == REG_IRQ_EN || paddr == REG_IRQ_CLR);
    badEv = 1'b0;
    if (wr && paddr == REG_CTRL) begin
      next_reqMode = line_mode_e'(pwdata[CTRL_MODE_LSB +: 2]);
      if (pwdata[CTRL_PAT_LSB +: 3] < 3'(PAT_COUNT))
        next_pattern = pwdata[CTRL_PAT_LSB +: 3];
      else
        badEv = 1'b1;
    end
    // leave ringing on trip, the request falls back to active
    if (tripEv)
      next_reqMode = MODE_ACTIVE;
    if (wr && paddr == REG_IRQ_EN)
      next_irqEn = pwdata[2:0];
    if (wr && paddr == REG_IRQ_CLR)
      next_irqSt = irqSt & ~pwdata[2:0];
    // set wins over clear
    next_irqSt[IRQ_TRIP]    = next_irqSt[IRQ_TRIP] | tripEv;
    next_irqSt[IRQ_HOOK]    = next_irqSt[IRQ_HOOK] | hookEv;
    next_irqSt[IRQ_ILLEGAL] = next_irqSt[IRQ_ILLEGAL] | badEv;
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reqMode <= line_mode_e'(CTRL_RESET[1:0]);
      pattern <= 3'h0;
      irqSt   <= 3'h0;
      irqEn   <= 3'h0;
    end else begin
      reqMode <= next_reqMode;
      pattern <= next_pattern;
      irqSt   <= next_irqSt;
      irqEn   <= next_irqEn;
    end
  end
  assign pready = 1'b1;
  assign irq    = |(irqSt & irqEn);
  // ==========================================================
  // cadence sequencer; ms tick keeps counters small
  logic [15:0] tickCnt, next_tickCnt;
  logic [12:0] msCnt, next_msCnt;
  logic [2:0]  step, next_step;
  logic        ringOn, next_ringOn;
  logic        tick;
  step_ms_t    stepLen;
  always_comb begin
    tick = tickCnt == 16'(TICK - 1);
    next_tickCnt = tick ? 16'h0000 : tickCnt + 16'h0001;
    stepLen = PATTERNS[pattern][step];
    next_msCnt = msCnt;
    next_step  = step;
    if (reqMode != MODE_RINGING || tripEv) begin
      next_msCnt = 13'h0000;
      next_step  = 3'h0;
    end else if (tick) begin
      if (msCnt + 13'h0001 >= stepLen) begin
        next_msCnt = 13'h0000;
        if (step == 3'(PAT_STEPS - 1) || PATTERNS[pattern][step + 3'h1] == 13'h0000)
          next_step = 3'h0;
        else
          next_step = step + 3'h1;
      end else begin
        next_msCnt = msCnt + 13'h0001;
      end
    end
    // even steps ring, odd steps silent
    next_ringOn = reqMode == MODE_RINGING && !tripEv && !next_step[0];
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tickCnt <= 16'h0000;
      msCnt   <= 13'h0000;
      step    <= 3'h0;
      ringOn  <= 1'b0;
    end else begin
      tickCnt <= next_tickCnt;
      msCnt   <= next_msCnt;
      step    <= next_step;
      ringOn  <= next_ringOn;
    end
  end
  // ==========================================================
  // mode lines and detector qualification
  logic pdn, bsel, rcl, next_pdn, next_bsel, next_rcl;
  logic hookPrev, next_hookPrev, offHook, next_offHook, tripSeen;
  logic [2:0] settleCnt, next_settleCnt;
  logic       settled;
  always_comb begin
    next_pdn  = reqMode != MODE_DENIAL;
    next_bsel = reqMode == MODE_STANDBY || reqMode == MODE_RINGING;
    next_rcl  = reqMode == MODE_RINGING && next_ringOn;
    // qualify detectors on the mode actually driven
    tripSeen = pdn && bsel && rcl && !ds2[0];
    tripEv   = tripSeen;
    // detectors lag the lines; stale ringing current is not off-hook
    settled = settleCnt == 3'(SETTLE_CYCLES);
    if ({next_pdn, next_bsel, next_rcl} != {pdn, bsel, rcl})
      next_settleCnt = 3'h0;
    else if (settled)
      next_settleCnt = settleCnt;
    else
      next_settleCnt = settleCnt + 3'h1;
    next_offHook = offHook;
    if (pdn && !rcl && settled)
      next_offHook = !ds2[1];
    next_hookPrev = offHook;
    hookEv = offHook != hookPrev;
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pdn       <= 1'b0;
      bsel      <= 1'b0;
      rcl       <= 1'b0;
      offHook   <= 1'b0;
      hookPrev  <= 1'b0;
      settleCnt <= 3'h0;
    end else begin
      pdn       <= next_pdn;
      bsel      <= next_bsel;
      rcl       <= next_rcl;
      offHook   <= next_offHook;
      hookPrev  <= next_hookPrev;
      settleCnt <= next_settleCnt;
    end
  end
  assign line.power_deny_n     = pdn;
  assign line.batterySelect    = bsel;
  assign line.ring_cadence_ctl = rcl;
  // ==========================================================
  // read mux
  always_ff @(posedge clk) begin
    if (!rst_n)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite) begin
      case (paddr)
        REG_CTRL:   prdata <= {25'h0, pattern, 2'h0, 2'(reqMode)};
        REG_STATUS: prdata <= {27'h0, step == 3'h0 && !rcl, offHook,
                               rcl, bsel, pdn};
        REG_IRQ_ST: prdata <= {29'h0, irqSt};
        REG_IRQ_EN: prdata <= {29'h0, irqEn};
        default:    prdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- core/slic_ctl_if.sv ----
// mode lines and detector outputs between controller and line interface
`timescale 1ns/10ps
`default_nettype none
interface slic_ctl_if;
  logic batterySelect;
  logic power_deny_n;
  logic ring_cadence_ctl;
  logic hook_detect_n;
  logic ring_trip_detect_n;
  modport controller (
    output batterySelect, power_deny_n, ring_cadence_ctl,
    input  hook_detect_n, ring_trip_detect_n
  );
  modport line (
    input  batterySelect, power_deny_n, ring_cadence_ctl,
    output hook_detect_n, ring_trip_detect_n
  );
endinterface
`default_nettype wire

// ---- core/slic_line_end.sv ----
// line interface end: mode decode and detector gating
`timescale 1ns/10ps
`default_nettype none
module slic_line_end
  import slic_mode_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // control lines
  slic_ctl_if.line  bus,
  // analogue side, abstracted
  input  wire logic loopCurrentAbove,
  input  wire logic ringTripSense,
  output logic      highBattery,
  output logic      centeringOn,
  output logic      standby_clamp_voltage,
  output logic      ringing_signal_input,
  output logic      denialLimit,
  output logic      modeInvalid,
  output line_mode_e lineMode
);
  // ==========================================================
  // input synchronisers
  logic [2:0] s1, s2, next_s1;
  // only the second stage is read
  logic [1:0] d1, d, next_d;
  line_mode_e next_mode;
  logic       next_inv;
  always_comb begin
    next_s1 = {bus.batterySelect, bus.power_deny_n, bus.ring_cadence_ctl};
    next_d  = {loopCurrentAbove, ringTripSense};
    next_inv = 1'b0;
    if (!s2[1]) begin
      next_mode = MODE_DENIAL;
      next_inv  = s2[0];
    end else if (!s2[0]) begin
      next_mode = s2[2] ? MODE_STANDBY : MODE_ACTIVE;
    end else begin
      next_mode = s2[2] ? MODE_RINGING : MODE_ACTIVE;
      next_inv  = !s2[2];
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1          <= 3'h0;
      s2          <= 3'h0;
      d1          <= 2'h0;
      d           <= 2'h0;
      lineMode    <= MODE_DENIAL;
      modeInvalid <= 1'b0;
    end else begin
      s1          <= next_s1;
      s2          <= s1;
      d1          <= next_d;
      d           <= d1;
      lineMode    <= next_mode;
      modeInvalid <= next_inv;
    end
  end
  // ==========================================================
  // outputs; detectors read high (inactive) when not valid
  always_comb begin
    highBattery           = s2[2];
    centeringOn           = s2[0];
    // the clamp only bites on the high battery
    standby_clamp_voltage = !s2[0] && s2[2];
    ringing_signal_input  = lineMode == MODE_RINGING;
    denialLimit           = lineMode == MODE_DENIAL;
    // ringing current trips the hook detector both ways
    bus.hook_detect_n = !((lineMode != MODE_DENIAL) &&
                          (d[1] || lineMode == MODE_RINGING));
    bus.ring_trip_detect_n = !(lineMode == MODE_RINGING && d[0]);
  end
endmodule
`default_nettype wire

// ---- core/slic_mode_pkg.sv ----
// shared constants and types for the line interface mode control
package slic_mode_pkg;
  // ==========================================================
  // clock and timing
  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned TICK_MS       = 1;
  localparam int unsigned TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
  // lines to detector round trip, both sync pairs included
  localparam int unsigned SETTLE_CYCLES = 6;
  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_STATUS  = 8'h04;
  localparam logic [7:0] REG_IRQ_ST  = 8'h08;
  localparam logic [7:0] REG_IRQ_EN  = 8'h0C;
  localparam logic [7:0] REG_IRQ_CLR = 8'h10;
  // ctrl fields
  localparam int CTRL_MODE_LSB = 0;   // 2 bits
  localparam int CTRL_PAT_LSB  = 4;   // 3 bits
  // irq bits
  localparam int IRQ_TRIP   = 0;
  localparam int IRQ_HOOK   = 1;
  localparam int IRQ_ILLEGAL = 2;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // ==========================================================
  // modes and cadence
  typedef enum logic [1:0] {
    MODE_DENIAL, MODE_ACTIVE, MODE_STANDBY, MODE_RINGING
  } line_mode_e;
  localparam int PAT_STEPS = 6;
  localparam int PAT_COUNT = 7;
  // interval lengths in ms, ringing/silent alternate, 0 ends the pattern
  typedef logic [12:0] step_ms_t;
  typedef step_ms_t pattern_t [PAT_STEPS];
  localparam pattern_t PATTERNS [PAT_COUNT] = '{
    '{13'd400, 13'd200, 13'd400, 13'd200, 13'd800, 13'd4000},  // A
    '{13'd200, 13'd100, 13'd200, 13'd100, 13'd600, 13'd4000},  // B
    '{13'd800, 13'd400, 13'd800, 13'd400, 13'd0,   13'd0},     // C
    '{13'd400, 13'd200, 13'd600, 13'd4000, 13'd0,  13'd0},     // D
    '{13'd1200, 13'd4000, 13'd0, 13'd0,   13'd0,   13'd0},     // E
    '{13'd1000, 13'd3000, 13'd0, 13'd0,   13'd0,   13'd0},     // F
    '{13'd300, 13'd200, 13'd1000, 13'd200, 13'd300, 13'd4000}  // G
  };
endpackage

// ---- tb/slic_mode_checker.sv ----
// assertion checker for the mode lines and detector outputs
`timescale 1ns/10ps
`default_nettype none
module slic_mode_checker (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // watched interface lines
  input wire logic batterySelect,
  input wire logic power_deny_n,
  input wire logic ring_cadence_ctl,
  input wire logic hook_detect_n,
  input wire logic ring_trip_detect_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // mode lines
  a_reset_denial: assert property ($rose(rst_n) |->
    !power_deny_n && !batterySelect && !ring_cadence_ctl) else $error("bad reset");
  a_deny_cadence: assert property (!power_deny_n |-> !ring_cadence_ctl)
    else $error("cadence in denial");
  a_cadence_batt: assert property (ring_cadence_ctl |-> batterySelect)
    else $error("cadence on low battery");
  a_burst_min: assert property ($rose(ring_cadence_ctl) |->
    ring_cadence_ctl[*8]) else $error("burst too short");
  // ==========================================================
  // detectors; six cycles cover both sync stages plus decode
  a_deny_hook: assert property (!power_deny_n[*6] |-> hook_detect_n)
    else $error("hook valid in denial");
  a_deny_trip: assert property (!power_deny_n[*6] |-> ring_trip_detect_n)
    else $error("trip valid in denial");
  a_standby_trip: assert property (
    (power_deny_n && batterySelect && !ring_cadence_ctl)[*6] |->
    ring_trip_detect_n) else $error("trip valid in standby");
  a_active_trip: assert property (
    (power_deny_n && !batterySelect)[*6] |-> ring_trip_detect_n)
    else $error("trip valid in active");
  a_trip_leaves: assert property ($fell(ring_trip_detect_n) |->
    ##[1:12] (power_deny_n && !batterySelect && !ring_cadence_ctl))
    else $error("ringing kept after trip");
  c_burst: cover property ($rose(ring_cadence_ctl));
  c_trip: cover property ($fell(ring_trip_detect_n));
  c_active: cover property ((power_deny_n && !batterySelect)[*8]);
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench joining controller and line interface ends
`timescale 1ns/10ps
`default_nettype none
`define CHECK(a, b) begin compares++; if ((a) !== (b)) begin badCount++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_top
  import slic_mode_pkg::*;
;
  localparam int TK = 5;
  // ==========================================================
  // signals
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel, penable, pwrite, loopCurrentAbove, ringTripSense;
  logic [7:0]  paddr, lfsr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, irq, highBattery, centeringOn, denialLimit;
  logic        standby_clamp_voltage, ringing_signal_input, modeInvalid;
  line_mode_e  lineMode;
  logic [32:0] expQ[$];
  logic [31:0] mskQ[$];
  logic [32:0] got, ex;
  logic [1:0]  m;
  logic [2:0]  p;
  int          badCount = 0, compares = 0, cycles = 0, n;
  slic_ctl_if ctlIf ();
  slic_controller #(.TICK(TK)) slic_controller_inst (.clk(clk),
    .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .line(ctlIf));
  slic_line_end slic_line_end_inst (.clk(clk), .rst_n(rst_n), .bus(ctlIf),
    .loopCurrentAbove(loopCurrentAbove), .ringTripSense(ringTripSense),
    .highBattery(highBattery), .centeringOn(centeringOn),
    .standby_clamp_voltage(standby_clamp_voltage),
    .ringing_signal_input(ringing_signal_input), .denialLimit(denialLimit),
    .modeInvalid(modeInvalid), .lineMode(lineMode));
  slic_mode_checker slic_mode_checker_inst (.clk(clk), .rst_n(rst_n),
    .batterySelect(ctlIf.batterySelect), .power_deny_n(ctlIf.power_deny_n),
    .ring_cadence_ctl(ctlIf.ring_cadence_ctl),
    .hook_detect_n(ctlIf.hook_detect_n),
    .ring_trip_detect_n(ctlIf.ring_trip_detect_n));
  always #10 clk = ~clk;
  // ==========================================================
  // helpers
  function automatic logic [7:0] step(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // one tick of slack: interval edges land on tick boundaries
  function automatic logic near(input int c, input int ms);
    return c >= (ms - 1) * TK && c <= (ms + 1) * TK;
  endfunction
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e,
                    input logic [31:0] k);
    expQ.push_back(e);
    mskQ.push_back(k);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic wt(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task automatic span(input logic v);
    n = 0;
    while (ctlIf.ring_cadence_ctl !== v) @(posedge clk);
    while (ctlIf.ring_cadence_ctl === v) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic stopTest;
    $display("compares %0d mismatches %0d", compares, badCount);
    if (badCount == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ==========================================================
  // read monitor and timeout
  always @(posedge clk) begin
    cycles++;
    if (cycles > 80000) begin
      badCount++;
      stopTest();
    end else if (psel && penable && pready && !pwrite && expQ.size() > 0) begin
      got = {pslverr, prdata & mskQ.pop_front()};
      ex = expQ.pop_front();
      `CHECK(got, ex)
    end
  end
  // ==========================================================
  // scenarios
  initial begin
    {psel, penable, pwrite, loopCurrentAbove, ringTripSense} = 5'h02;
    paddr = 8'h00;
    pwdata = 32'h0;
    lfsr = 8'h57;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd(REG_CTRL, {1'b0, CTRL_RESET}, 32'hFFFFFFFF);
    rd(REG_STATUS, 33'h0, 32'h7);
    wt(4);
    `CHECK({lineMode, denialLimit, ctlIf.hook_detect_n}, {MODE_DENIAL, 2'b11})
    $display("test reset done");
    for (int i = 1; i < 4; i++) begin
      m = 2'(i % 3);
      lfsr = step(lfsr);
      @(posedge clk);
      loopCurrentAbove <= lfsr[0];
      ringTripSense <= 1'b1;
      apb(1'b1, REG_CTRL, {30'h0, m});
      wt(8);
      `CHECK({lineMode, highBattery, denialLimit, modeInvalid}, {line_mode_e'(m), m[1], m == 2'd0, 1'b0})
      `CHECK({centeringOn, standby_clamp_voltage}, {1'b0, m == 2'd2})
      `CHECK({ctlIf.hook_detect_n, ctlIf.ring_trip_detect_n}, {m == 2'd0 | !loopCurrentAbove, 1'b1})
      rd(REG_STATUS, {28'h0, loopCurrentAbove, 1'b0, m[1], m != 2'd0},
         m == 2'd0 ? 32'h7 : 32'hF);
    end
    $display("test modes done");
    apb(1'b1, REG_IRQ_EN, 32'h5);
    apb(1'b1, REG_IRQ_CLR, 32'h7);
    @(posedge clk);
    ringTripSense <= 1'b0;
    for (int j = 0; j < 2; j++) begin
      lfsr = step(lfsr);
      p = j ? 3'd5 : 3'(lfsr % 7);
      apb(1'b1, REG_CTRL, 32'h2);
      apb(1'b1, REG_CTRL, {25'h0, p, 4'h3});
      span(1'b1);
      `CHECK(near(n, PATTERNS[p][0]), 1'b1)
      span(1'b0);
      `CHECK(near(n, PATTERNS[p][1]), 1'b1)
      wt(10);
      `CHECK({centeringOn, standby_clamp_voltage, highBattery, ringing_signal_input}, 4'b1011)
    end
    $display("test cadence done");
    @(posedge clk);
    ringTripSense <= 1'b1;
    wt(20);
    `CHECK({ctlIf.power_deny_n, ctlIf.batterySelect, ctlIf.ring_cadence_ctl, irq}, 4'b1001)
    rd(REG_CTRL, 33'h1, 32'h3);
    rd(REG_IRQ_ST, 33'h1, 32'h1);
    apb(1'b1, REG_IRQ_CLR, 32'h1);
    wt(3);
    `CHECK(irq, 1'b0)
    $display("test trip done");
    apb(1'b1, REG_CTRL, 32'h72);
    rd(REG_IRQ_ST, 33'h4, 32'h4);
    rd(8'h20, 33'h100000000, 32'h0);
    wt(3);
    `CHECK(irq, 1'b1)
    $display("test refusals done");
    wt(20);
    apb(1'b1, REG_IRQ_CLR, 32'h7);
    @(posedge clk);
    loopCurrentAbove <= !loopCurrentAbove;
    wt(20);
    rd(REG_IRQ_ST, 33'h2, 32'h2);
    rd(REG_STATUS, {28'h0, loopCurrentAbove, 3'h3}, 32'hF);
    wt(2);
    $display("test hook done");
    stopTest();
  end
endmodule
`default_nettype wire
